// [hw/sacc_consts.svh]
// Constants for the shunt amplifier calibration control block
`ifndef SACC_CONSTS_SVH
`define SACC_CONSTS_SVH

// ****************************************
// Sizes and codes
// ****************************************
`define SACC_NUM_AMPS      3
`define SACC_GAIN_W        2
`define SACC_GAIN_MAX      2'h3
`define SACC_TRIM_CNT_W    14

// ****************************************
// Timing
// ****************************************
`define SACC_CLK_PERIOD_NS 4
`define SACC_TRIM_TIME_NS  50000
// Longest time, so rounded down
`define SACC_TRIM_CYCLES   (`SACC_TRIM_TIME_NS / `SACC_CLK_PERIOD_NS)

`endif

// [hw/sacc_pkg.sv]
// Types for the shunt amplifier calibration control block
`include "sacc_consts.svh"

package sacc_pkg;

  typedef enum logic [1:0] {
    SACC_IDLE = 2'b01,
    SACC_RUN  = 2'b10
  } sacc_trim_state_t;

  typedef logic [`SACC_GAIN_W-1:0] sacc_gain_t;

endpackage

// [hw/sacc_top.sv]
// Shunt amplifier calibration and sense mode control
//
// Functional notes
// - Divider removal bit bypasses reference divider in the serial variant only, amplifiers run unidirectional.
// - Manual calibration shorts that amplifier's inputs and disconnects its load.
// - Without auto-calibration, each calibration bit affects only its own amplifier.
// - Calibration requests are taken anytime, regardless of bridge switching.
// - Pin-configured variant ignores calibration bits entirely.
// - Power-up trim starts once reference is detected above its minimum.
// - Power-up trim finishes within 50 us; outputs unreliable before.
// - With auto-calibration enabled, a calibration bit reruns the trim.
// - During any trim, every amplifier is forced to maximum gain.
// - Sense mode routes positive input to the phase switch node.
// - Sense mode forces negative pin as low-side monitor reference.
// - Sense mode enables amplifier when the gate drive period ends.
// - Sense mode shorts inputs when low-side transistor is commanded off.
// - Gain selectable among four levels, 5 to 40 V/V.
// - Outside sense mode, select bit picks positive or negative reference.
`timescale 1ns/1ps
`include "sacc_consts.svh"

module sacc_top
  import sacc_pkg::*;
#(
  parameter int NUM_AMPS    = `SACC_NUM_AMPS,
  parameter int TRIM_CYCLES = `SACC_TRIM_CYCLES
) (
  input  wire logic                    core_clk_i,
  input  wire logic                    rst_b_i,
  input  wire logic                    serial_variant_i,
  input  wire logic                    vref_ok_i,
  input  wire logic                    ref_divider_remove_i,
  input  wire logic                    auto_cal_enable_i,
  input  wire logic [NUM_AMPS-1:0]     amp_calibrate_request_i,
  input  wire logic                    drain_source_sense_select_i,
  input  wire logic                    lowside_monitor_ref_select_i,
  input  wire sacc_gain_t              amp_gain_i,
  input  wire logic [NUM_AMPS-1:0]     gate_drive_period_done_i,
  input  wire logic [NUM_AMPS-1:0]     lowside_off_cmd_i,
  output logic                         ref_divider_bypass_o,
  output logic [NUM_AMPS-1:0]          amp_input_short_o,
  output logic [NUM_AMPS-1:0]          amp_load_disconnect_o,
  output logic [2*NUM_AMPS-1:0]        amp_gain_sel_o,
  output logic [NUM_AMPS-1:0]          amp_enable_o,
  output logic [NUM_AMPS-1:0]          amp_pos_to_switch_node_o,
  output logic                         lowside_ref_negative_o,
  output logic                         trim_busy_o,
  output logic                         amp_ready_o
);

  logic                  vref_meta_r;
  logic                  vref_sync_r;
  logic                  strap_meta_r;
  logic                  strap_sync_r;
  logic                  serial_r;
  logic                  strap_taken_r;
  logic                  pwrup_started_r;
  logic [NUM_AMPS-1:0]   cal_req_prev_r;
  logic                  trim_start_w;
  logic                  trim_busy_w;
  logic                  trim_done_w;
  logic                  rerun_w;
  logic [NUM_AMPS-1:0]   manual_cal_w;
  logic [NUM_AMPS-1:0]   dss_short_r;

  // Trim length watch counter, one bit wider than the sequencer's count
  localparam int TRIM_LEN_W = `SACC_TRIM_CNT_W + 1;
  logic [TRIM_LEN_W-1:0] trim_len_r;

  // ****************************************
  // Input synchronisers and strap capture
  // ****************************************
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      vref_meta_r  <= 1'b0;
      vref_sync_r  <= 1'b0;
      strap_meta_r <= 1'b0;
      strap_sync_r <= 1'b0;
    end else begin
      vref_meta_r  <= vref_ok_i;
      vref_sync_r  <= vref_meta_r;
      strap_meta_r <= serial_variant_i;
      strap_sync_r <= strap_meta_r;
    end
  end

  // Variant is fixed from the synchronised strap when the reference is first detected
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      serial_r      <= 1'b0;
      strap_taken_r <= 1'b0;
    end else if (!strap_taken_r && vref_sync_r) begin
      serial_r      <= strap_sync_r;
      strap_taken_r <= 1'b1;
    end
  end

  // ****************************************
  // Trim start decision
  // ****************************************
  // Rerun on a rising request bit; no bridge state gates it
  assign rerun_w = serial_r && auto_cal_enable_i &&
                   (|(amp_calibrate_request_i & ~cal_req_prev_r));
  assign trim_start_w = (vref_sync_r && !pwrup_started_r) || rerun_w;

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pwrup_started_r <= 1'b0;
      cal_req_prev_r  <= '0;
    end else begin
      cal_req_prev_r <= amp_calibrate_request_i;
      if (vref_sync_r) begin
        pwrup_started_r <= 1'b1;
      end
    end
  end

  sacc_trim_seq #(
    .CNT_W       (`SACC_TRIM_CNT_W),
    .TRIM_CYCLES (TRIM_CYCLES)
  ) u_trim (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .start_i    (trim_start_w),
    .busy_o     (trim_busy_w),
    .done_o     (trim_done_w)
  );

  // ****************************************
  // Status and shared routing
  // ****************************************
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      trim_busy_o <= 1'b0;
      amp_ready_o <= 1'b0;
    end else begin
      trim_busy_o <= trim_busy_w;
      if (trim_done_w && !amp_ready_o) begin
        amp_ready_o <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ref_divider_bypass_o   <= 1'b0;
      lowside_ref_negative_o <= 1'b0;
    end else begin
      ref_divider_bypass_o   <= serial_r && ref_divider_remove_i;
      // Sense mode must not leave the low-side monitor without a reference
      lowside_ref_negative_o <= (serial_r && drain_source_sense_select_i) ||
                                lowside_monitor_ref_select_i;
    end
  end

  // ****************************************
  // Per-amplifier control
  // ****************************************
  // Manual shorting only without run-time auto-calibration, serial variant only
  assign manual_cal_w = (serial_r && !auto_cal_enable_i) ?
                        amp_calibrate_request_i : '0;

  for (genvar i = 0; i < NUM_AMPS; i++) begin : g_amp
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        dss_short_r[i]              <= 1'b1;
        amp_enable_o[i]             <= 1'b0;
        amp_pos_to_switch_node_o[i] <= 1'b0;
      end else if (!(serial_r && drain_source_sense_select_i)) begin
        dss_short_r[i]              <= 1'b1;
        amp_enable_o[i]             <= 1'b1;
        amp_pos_to_switch_node_o[i] <= 1'b0;
      end else if (lowside_off_cmd_i[i]) begin
        // Off command wins a tie so the inputs never see a rising node
        dss_short_r[i]              <= 1'b1;
        amp_enable_o[i]             <= 1'b0;
        amp_pos_to_switch_node_o[i] <= 1'b0;
      end else if (gate_drive_period_done_i[i]) begin
        dss_short_r[i]              <= 1'b0;
        amp_enable_o[i]             <= 1'b1;
        amp_pos_to_switch_node_o[i] <= 1'b1;
      end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        amp_input_short_o[i]     <= 1'b0;
        amp_load_disconnect_o[i] <= 1'b0;
        amp_gain_sel_o[2*i +: 2] <= `SACC_GAIN_MAX;
      end else begin
        amp_input_short_o[i]     <= manual_cal_w[i] || trim_busy_w ||
                                    (serial_r && drain_source_sense_select_i &&
                                     dss_short_r[i]);
        amp_load_disconnect_o[i] <= manual_cal_w[i] || trim_busy_w;
        amp_gain_sel_o[2*i +: 2] <= trim_busy_w ? `SACC_GAIN_MAX : amp_gain_i;
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  // A delay range cannot span the whole trim time, so busy cycles are counted
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      trim_len_r <= '0;
    end else if (trim_busy_w) begin
      trim_len_r <= trim_len_r + TRIM_LEN_W'(1);
    end else begin
      trim_len_r <= '0;
    end
  end

  a_trim_gain_max: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    trim_busy_w |=> (amp_gain_sel_o == {NUM_AMPS{`SACC_GAIN_MAX}}))
    else $error("Gain not forced to maximum during trim");

  a_gain_restore: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    !trim_busy_w |=> (amp_gain_sel_o[1:0] == $past(amp_gain_i)))
    else $error("Programmed gain not applied outside trim");

  a_pwrup_start: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    $rose(vref_sync_r) && !pwrup_started_r |=> trim_busy_w)
    else $error("Power-up trim did not start on reference");

  a_trim_length: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    trim_busy_w |-> (trim_len_r < TRIM_LEN_W'(TRIM_CYCLES)))
    else $error("Trim exceeded its window");

  a_pin_no_cal: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    !serial_r && !trim_busy_w && !drain_source_sense_select_i |=> !(|amp_load_disconnect_o))
    else $error("Calibration acted on pin variant");

  a_manual_short: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    manual_cal_w[0] |=> amp_input_short_o[0] && amp_load_disconnect_o[0])
    else $error("Manual calibration did not short amplifier");

  a_own_amp: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    !manual_cal_w[1] && !trim_busy_w |=> !amp_load_disconnect_o[1])
    else $error("Calibration leaked to another amplifier");

  a_ref_divider: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    ##1 ref_divider_bypass_o == $past(serial_r && ref_divider_remove_i))
    else $error("Divider bypass mismatch");

  a_dss_ref: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    serial_r && drain_source_sense_select_i |=> lowside_ref_negative_o)
    else $error("Sense mode did not force negative reference");

  a_dss_off_short: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    serial_r && drain_source_sense_select_i && lowside_off_cmd_i[0] |=> ##1 amp_input_short_o[0])
    else $error("Off command did not short inputs");

  a_dss_enable: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    serial_r && drain_source_sense_select_i && gate_drive_period_done_i[0] && !lowside_off_cmd_i[0]
    |=> amp_enable_o[0] && amp_pos_to_switch_node_o[0])
    else $error("Amplifier not enabled after gate drive period");

endmodule

// [hw/sacc_trim_seq.sv]
// Automatic offset trim sequencer: runs a fixed-length trim after a start pulse
`timescale 1ns/1ps
`include "sacc_consts.svh"

module sacc_trim_seq
  import sacc_pkg::*;
#(
  parameter int CNT_W       = `SACC_TRIM_CNT_W,
  parameter int TRIM_CYCLES = `SACC_TRIM_CYCLES
) (
  input  wire logic core_clk_i,
  input  wire logic rst_b_i,
  input  wire logic start_i,
  output logic      busy_o,
  output logic      done_o
);

  sacc_trim_state_t   state_r;
  logic [CNT_W-1:0]   cnt_r;
  logic               last_w;

  assign last_w = (cnt_r == CNT_W'(TRIM_CYCLES - 1));

  // ****************************************
  // Sequencer
  // ****************************************
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_r <= SACC_IDLE;
      cnt_r   <= '0;
      done_o  <= 1'b0;
    end else begin
      done_o <= 1'b0;
      case (state_r)
        SACC_IDLE: begin
          cnt_r <= '0;
          if (start_i) begin
            state_r <= SACC_RUN;
          end
        end
        SACC_RUN: begin
          // Fixed length keeps the trim inside its allowed window
          if (last_w) begin
            state_r <= SACC_IDLE;
            done_o  <= 1'b1;
          end else begin
            cnt_r <= cnt_r + CNT_W'(1);
          end
        end
        default: begin
          state_r <= SACC_IDLE;
        end
      endcase
    end
  end

  assign busy_o = (state_r == SACC_RUN);

endmodule

// [sim/sacc_ctrl_model.sv]
// Controller model: gate drive timing pulses toward the block
`timescale 1ns/1ps

module sacc_ctrl_model (
  input  wire logic core_clk_i,
  output logic [2:0] gate_drive_period_done_o,
  output logic [2:0] lowside_off_cmd_o
);
  initial begin
    gate_drive_period_done_o = 3'h0;
    lowside_off_cmd_o        = 3'h0;
  end

  // One-cycle pulses, launched and cleared on falling edges
  task automatic pulse(input logic [2:0] d, input logic [2:0] o);
    @(negedge core_clk_i);
    gate_drive_period_done_o = d;
    lowside_off_cmd_o        = o;
    @(negedge core_clk_i);
    gate_drive_period_done_o = 3'h0;
    lowside_off_cmd_o        = 3'h0;
  endtask
endmodule

// [sim/tb.sv]
// Self-checking bench for the shunt amplifier calibration control
`timescale 1ns/1ps

module tb;
  import sacc_pkg::*;
  localparam int TC = 20;
  logic       clk, rst_b, serial, vref, divrm, autocal, dss, lsel, bypass, lsneg, tbusy, ready;
  logic [2:0] req, done, off, shrt, disc, en, pos;
  logic [5:0] gsel;
  sacc_gain_t gain;
  int         errors = 0;
  int         n_tests = 0;
  int         cycles = 0;
  int         n;

  sacc_top #(.NUM_AMPS(3), .TRIM_CYCLES(TC)) i_dut (
    .core_clk_i(clk), .rst_b_i(rst_b), .serial_variant_i(serial), .vref_ok_i(vref),
    .ref_divider_remove_i(divrm), .auto_cal_enable_i(autocal), .amp_calibrate_request_i(req),
    .drain_source_sense_select_i(dss), .lowside_monitor_ref_select_i(lsel), .amp_gain_i(gain),
    .gate_drive_period_done_i(done), .lowside_off_cmd_i(off), .ref_divider_bypass_o(bypass),
    .amp_input_short_o(shrt), .amp_load_disconnect_o(disc), .amp_gain_sel_o(gsel),
    .amp_enable_o(en), .amp_pos_to_switch_node_o(pos), .lowside_ref_negative_o(lsneg),
    .trim_busy_o(tbusy), .amp_ready_o(ready)
  );

  sacc_ctrl_model i_ctrl (
    .core_clk_i(clk), .gate_drive_period_done_o(done), .lowside_off_cmd_o(off)
  );

  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask

  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Bounded waits so a stuck trim cannot hang the run
  task automatic trim_chk(input string nm);
    n = 0;
    while (tbusy !== 1'b1 && n < 8) begin
      cyc(1);
      n++;
    end
    chk({nm, " start"}, 8'(n < 8), 8'h1);
    chk({nm, " gain"}, gsel, 8'h3F);
    n = 0;
    while (tbusy === 1'b1 && n < 100) begin
      cyc(1);
      n++;
    end
    chk({nm, " length"}, 8'(n), 8'(TC));
    cyc(2);
    chk({nm, " restore"}, gsel, {3{gain}});
    $display("Test %s finished", nm);
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      stop_test();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(44));
    {rst_b, vref, divrm, autocal, req, dss, lsel} = '0;
    serial = 1'b1;
    gain   = 2'h1;
    cyc(5);
    rst_b = 1'b1;
    vref  = 1'b1;
    trim_chk("power-up");
    chk("ready", ready, 8'h1);
    for (int g = 0; g < 4; g++) begin
      gain  = sacc_gain_t'(g);
      divrm = 1'($urandom);
      lsel  = 1'($urandom);
      cyc(2);
      chk("gain", gsel, {3{gain}});
      chk("bypass", bypass, divrm);
      chk("monitor ref", lsneg, lsel);
    end
    $display("Test levels finished");
    i_ctrl.pulse(3'h0, 3'h7);
    for (int i = 0; i < 3; i++) begin
      req = 3'(1 << i);
      i_ctrl.pulse(3'($urandom), 3'($urandom));
      chk("cal short", shrt, req);
      chk("cal disconnect", disc, req);
      req = 3'h0;
      cyc(2);
    end
    $display("Test manual calibration finished");
    dss  = 1'b1;
    lsel = 1'b0;
    cyc(2);
    chk("sense ref", lsneg, 8'h1);
    i_ctrl.pulse(3'h1, 3'h0);
    cyc(1);
    chk("after drive", {en[0], pos[0], shrt[0]}, 8'h6);
    i_ctrl.pulse(3'h0, 3'h1);
    cyc(1);
    chk("after off", {en[0], pos[0], shrt[0]}, 8'h1);
    i_ctrl.pulse(3'h1, 3'h0);
    i_ctrl.pulse(3'h1, 3'h1);
    cyc(1);
    chk("tie", {en[0], pos[0], shrt[0]}, 8'h1);
    dss = 1'b0;
    cyc(2);
    $display("Test sense mode finished");
    autocal = 1'b1;
    gain    = 2'h2;
    req     = 3'h2;
    trim_chk("rerun");
    req     = 3'h0;
    autocal = 1'b0;
    rst_b   = 1'b0;
    serial  = 1'b0;
    vref    = 1'b0;
    cyc(5);
    rst_b = 1'b1;
    vref  = 1'b1;
    trim_chk("pin variant");
    divrm = 1'b1;
    dss   = 1'b1;
    req   = 3'h7;
    cyc(3);
    chk("pin bits", {bypass, shrt, pos}, 8'h0);
    chk("pin disc", {lsneg, disc, en}, 8'h7);
    $display("Test pin variant finished");
    stop_test();
  end
endmodule
